/* File: design/cal_engine.v */
// offset and gain calibration engine behind the converter command port
// assumes commands, register accesses and filtered results come from logic
// on ref_clk; only sync_pin arrives from a pin and is synchronised here
`timescale 1ns/1ps
`default_nettype none
`include "cal_engine_consts.vh"

module cal_engine (
    // clock and reset
    input wire ref_clk,
    input wire rst,

    // filtered conversion results, one pulse per data period
    input wire filt_valid,
    input wire [31:0] filt_data,

    // decoded command bytes
    input wire cmd_valid,
    input wire [7:0] cmd_code,

    // register port
    input wire reg_wr,
    input wire reg_rd,
    input wire [4:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,

    // serial side: first shift clock edge of a data read
    input wire data_read,

    // external synchronisation pin
    input wire sync_pin,

    // corrected results
    output reg result_valid,
    output reg [31:0] result_data,
    output reg result_ready_strobe_n,

    // status
    output reg cal_busy,
    output reg cal_abort,
    output reg cont_read_on
);

    // one-hot calibration states
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_ARMED = 4'b0010;
    localparam [3:0] ST_ACCUM = 4'b0100;
    localparam [3:0] ST_DIVIDE = 4'b1000;

    // merge one byte into a 24-bit word
    function [23:0] put_byte;
        input [23:0] word;
        input [1:0] sel;
        input [7:0] data;
        begin
            put_byte = word;
            case (sel)
                2'd0: put_byte[7:0] = data;
                2'd1: put_byte[15:8] = data;
                default: put_byte[23:16] = data;
            endcase
        end
    endfunction

    reg sync_meta_reg;
    reg sync_level_reg;
    reg [23:0] offset_reg;
    reg [23:0] gain_reg;
    reg cont_read_reg;
    reg [3:0] state_reg;
    reg cal_gain_reg;
    reg [4:0] count_reg;
    reg [35:0] acc_reg;
    reg [32:0] div_rem_reg;
    reg [31:0] div_d_reg;
    reg [23:0] div_q_reg;
    reg [4:0] div_step_reg;
    reg [2:0] strobe_cnt_reg;

    wire scaled_valid;
    wire [31:0] scaled_data;

    // sync pin passes two flops before anything looks at it
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync_meta_reg <= 1'b0;
            sync_level_reg <= 1'b0;
        end else begin
            sync_meta_reg <= sync_pin;
            sync_level_reg <= sync_meta_reg;
        end
    end

    // calibration in progress from arming through the divide
    wire cal_active = (state_reg != ST_IDLE);
    wire measuring = (state_reg == ST_ACCUM);

    // measure raw readings: no gain while measuring, no offset during an offset calibration
    wire [23:0] eff_offset = (measuring && !cal_gain_reg) ?
        `OFFSET_RESET : offset_reg;
    wire eff_bypass = measuring;

    scale_unit u_scale (
        .ref_clk(ref_clk),
        .rst(rst),
        .in_valid(filt_valid),
        .in_data(filt_data),
        .offset_word(eff_offset),
        .gain_word(gain_reg),
        .gain_bypass(eff_bypass),
        .out_valid(scaled_valid),
        .out_data(scaled_data)
    );

    // running sum including the reading now arriving
    wire [35:0] acc_sum = acc_reg + {{4{scaled_data[31]}}, scaled_data};
    wire [31:0] avg = acc_sum[35:`CAL_AVG_SHIFT];
    wire last_reading = (count_reg == `CAL_READINGS - 5'd1);

    // magnitude of the measured full-scale reading
    wire [31:0] avg_mag = avg[31] ?
        ((avg == 32'h80000000) ? 32'h7FFFFFFF : (~avg + 32'h00000001)) : avg;

    // gain = 2^53 / magnitude; too small a magnitude clamps the gain
    wire gain_clamp = ({1'b0, avg_mag} <= `DIV_START_REM);

    // restoring divide step
    wire [32:0] rem_sh = {div_rem_reg[31:0], 1'b0};
    wire rem_ge = (rem_sh >= {1'b0, div_d_reg});
    wire [32:0] rem_sub = rem_sh - {1'b0, div_d_reg};
    wire [23:0] q_next = {div_q_reg[22:0], rem_ge};
    wire div_done = (div_step_reg == `DIV_STEPS - 5'd1);

    // completion pulses write the words in this same cycle
    wire ofs_done = measuring && scaled_valid && last_reading && !cal_gain_reg;
    wire gain_fast = measuring && scaled_valid && last_reading &&
        cal_gain_reg && gain_clamp;
    wire gain_done = (state_reg == ST_DIVIDE) && div_done;

    // register write decode
    wire wr_ofs = reg_wr && (reg_addr == `OFS_LOW_ADDR ||
        reg_addr == `OFS_MID_ADDR || reg_addr == `OFS_HIGH_ADDR);
    wire wr_gain = reg_wr && (reg_addr == `GAIN_LOW_ADDR ||
        reg_addr == `GAIN_MID_ADDR || reg_addr == `GAIN_HIGH_ADDR);
    wire [1:0] ofs_sel = (reg_addr == `OFS_LOW_ADDR) ? 2'd0 :
        (reg_addr == `OFS_MID_ADDR) ? 2'd1 : 2'd2;
    wire [1:0] gain_sel = (reg_addr == `GAIN_LOW_ADDR) ? 2'd0 :
        (reg_addr == `GAIN_MID_ADDR) ? 2'd1 : 2'd2;

    // offset word: calibration result beats a host write in the same cycle
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            offset_reg <= `OFFSET_RESET;
        end else if (ofs_done) begin
            offset_reg <= avg[31:8];
        end else if (wr_ofs) begin
            offset_reg <= put_byte(offset_reg, ofs_sel, reg_wdata);
        end
    end

    // gain word: same priority as the offset word
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            gain_reg <= `GAIN_RESET;
        end else if (gain_fast) begin
            gain_reg <= `GAIN_MAX;
        end else if (gain_done) begin
            gain_reg <= q_next;
        end else if (wr_gain) begin
            gain_reg <= put_byte(gain_reg, gain_sel, reg_wdata);
        end
    end

    // register reads, unmapped indices answer zero
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `OFS_LOW_ADDR: reg_rdata <= offset_reg[7:0];
                `OFS_MID_ADDR: reg_rdata <= offset_reg[15:8];
                `OFS_HIGH_ADDR: reg_rdata <= offset_reg[23:16];
                `GAIN_LOW_ADDR: reg_rdata <= gain_reg[7:0];
                `GAIN_MID_ADDR: reg_rdata <= gain_reg[15:8];
                `GAIN_HIGH_ADDR: reg_rdata <= gain_reg[23:16];
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // continuous-read mode, on by default
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cont_read_reg <= 1'b1;
        end else if (cmd_valid && cmd_code == `CMD_CONTINUOUS_READ_CMD) begin
            cont_read_reg <= 1'b1;
        end else if (cmd_valid && cmd_code == `CMD_STOP_CONTINUOUS_READ_CMD) begin
            cont_read_reg <= 1'b0;
        end
    end

    // calibration sequencer; a calibration command only arms while
    // continuous read is stopped, and the next continuous-read starts it
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            cal_gain_reg <= 1'b0;
            count_reg <= 5'd0;
            acc_reg <= 36'h000000000;
            div_rem_reg <= 33'h000000000;
            div_d_reg <= 32'h00000000;
            div_q_reg <= 24'h000000;
            div_step_reg <= 5'd0;
        end else if (cal_active && !sync_level_reg) begin
            // sync pin dropped: the averages would be meaningless
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (cmd_valid && !cont_read_reg &&
                        (cmd_code == `CMD_OFFSET_CAL_COMMAND ||
                         cmd_code == `CMD_GAIN_CAL_COMMAND)) begin
                        state_reg <= ST_ARMED;
                        cal_gain_reg <= (cmd_code == `CMD_GAIN_CAL_COMMAND);
                    end
                end
                ST_ARMED: begin
                    if (cmd_valid && cmd_code == `CMD_CONTINUOUS_READ_CMD) begin
                        state_reg <= ST_ACCUM;
                        count_reg <= 5'd0;
                        acc_reg <= 36'h000000000;
                    end
                end
                ST_ACCUM: begin
                    // first 16 readings, so done inside 16 periods
                    if (scaled_valid) begin
                        acc_reg <= acc_sum;
                        count_reg <= count_reg + 5'd1;
                        if (last_reading) begin
                            if (!cal_gain_reg || gain_clamp) begin
                                state_reg <= ST_IDLE;
                            end else begin
                                state_reg <= ST_DIVIDE;
                                div_d_reg <= avg_mag;
                                div_rem_reg <= `DIV_START_REM;
                                div_q_reg <= 24'h000000;
                                div_step_reg <= 5'd0;
                            end
                        end
                    end
                end
                ST_DIVIDE: begin
                    // 24 cycles, far shorter than one data period
                    div_rem_reg <= rem_ge ? rem_sub : rem_sh;
                    div_q_reg <= q_next;
                    div_step_reg <= div_step_reg + 5'd1;
                    if (div_done) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // abort flag: set by a lost sync, cleared by the next calibration
    // command; a set in the same cycle wins
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cal_abort <= 1'b0;
        end else if (cal_active && !sync_level_reg) begin
            cal_abort <= 1'b1;
        end else if (cmd_valid && (cmd_code == `CMD_OFFSET_CAL_COMMAND ||
                                   cmd_code == `CMD_GAIN_CAL_COMMAND)) begin
            cal_abort <= 1'b0;
        end
    end

    // result and status outputs, all registered
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            result_valid <= 1'b0;
            result_data <= 32'h00000000;
            cal_busy <= 1'b0;
            cont_read_on <= 1'b1;
        end else begin
            result_valid <= scaled_valid;
            if (scaled_valid) begin
                result_data <= scaled_data;
            end
            cal_busy <= cal_active;
            cont_read_on <= cont_read_reg;
        end
    end

    // ready strobe: high for four clocks at each update, then low until
    // read; held high while continuous read is stopped
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            result_ready_strobe_n <= 1'b1;
            strobe_cnt_reg <= 3'd0;
        end else if (!cont_read_reg) begin
            result_ready_strobe_n <= 1'b1;
            strobe_cnt_reg <= 3'd0;
        end else if (scaled_valid) begin
            result_ready_strobe_n <= 1'b1;
            strobe_cnt_reg <= `STROBE_HIGH_CYCLES;
        end else if (strobe_cnt_reg != 3'd0) begin
            strobe_cnt_reg <= strobe_cnt_reg - 3'd1;
            if (strobe_cnt_reg == 3'd1) begin
                result_ready_strobe_n <= 1'b0;
            end
        end else if (data_read) begin
            result_ready_strobe_n <= 1'b1;
        end
    end

endmodule // cal_engine

`default_nettype wire

/* File: design/scale_unit.v */
// offset subtraction, gain scaling and saturation, one register stage
// assumes in_valid is a one-cycle pulse on ref_clk, words stable meanwhile
`timescale 1ns/1ps
`default_nettype none
`include "cal_engine_consts.vh"

module scale_unit (
    // clock and reset
    input wire ref_clk,
    input wire rst,
    // filtered sample
    input wire in_valid,
    input wire [31:0] in_data,
    // correction words and mode
    input wire [23:0] offset_word,
    input wire [23:0] gain_word,
    input wire gain_bypass,
    // scaled sample
    output reg out_valid,
    output reg [31:0] out_data
);

    // clamp a wide signed value into 32 bits
    function [31:0] sat32;
        input [56:0] v;
        begin
            if (&v[56:31] || ~|v[56:31]) begin
                sat32 = v[31:0];
            end else begin
                sat32 = {v[56], {31{~v[56]}}};
            end
        end
    endfunction

    // offset sits on the upper 24 bits, sign extended
    wire [56:0] in_ext = {{25{in_data[31]}}, in_data};
    wire [56:0] ofs_ext = {{25{offset_word[23]}}, offset_word, 8'h00};
    wire [56:0] diff_w = in_ext - ofs_ext;
    wire [31:0] diff_sat = sat32(diff_w);

    // full signed product; 2^31 * 2^24 still fits in 57 bits
    wire signed [56:0] diff_s = {{25{diff_sat[31]}}, diff_sat};
    wire signed [56:0] gain_s = {33'h0, gain_word};
    wire signed [56:0] prod = diff_s * gain_s;
    wire [56:0] prod_sh = {{22{prod[56]}}, prod[56:`GAIN_FRAC_BITS]};

    // subtract first, then scale by gain over 400000h
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            out_valid <= 1'b0;
            out_data <= 32'h00000000;
        end else begin
            out_valid <= in_valid;
            if (in_valid) begin
                out_data <= gain_bypass ? diff_sat : sat32(prod_sh);
            end
        end
    end

endmodule // scale_unit

`default_nettype wire

/* File: inc/cal_engine_consts.vh */
// constants for the offset and gain calibration engine
// assumes a 20 MHz ref_clk and filtered results from the decimation filter
//
// Functional notes
// - result minus offset word, then times gain word over 400000h
// - 24-bit two's complement offset sits on top bits of 32-bit result
// - offset word spans 7FFFFFh down to 800000h, full positive to negative
// - offset word resets to zero, so no offset correction at first
// - gain word unsigned 24 bits, linear, 400000h means exactly one
// - gain word resets to 400000h, so no gain correction at first
// - each word in three bytes: low bits 7-0, mid 15-8, high 23-16
// - words written by host, and overwritten when a calibration finishes
// - calibration done within 16 data periods after continuous-read follows
// - offset calibration averages 16 readings into the offset word
// - gain correction bypassed while offset calibration runs
// - gain calibration averages 16 readings, writes compensating gain word

`ifndef CAL_ENGINE_CONSTS_VH
`define CAL_ENGINE_CONSTS_VH

// register indices on the register port
`define OFS_LOW_ADDR 5'h00
`define OFS_MID_ADDR 5'h01
`define OFS_HIGH_ADDR 5'h02
`define GAIN_LOW_ADDR 5'h03
`define GAIN_MID_ADDR 5'h04
`define GAIN_HIGH_ADDR 5'h05

// reset values of the correction words
`define OFFSET_RESET 24'h000000
`define GAIN_RESET 24'h400000

// command codes
`define CMD_CONTINUOUS_READ_CMD 8'h10
`define CMD_STOP_CONTINUOUS_READ_CMD 8'h11
`define CMD_OFFSET_CAL_COMMAND 8'h60
`define CMD_GAIN_CAL_COMMAND 8'h61

// gain arithmetic
`define GAIN_FRAC_BITS 22
`define GAIN_MAX 24'hFFFFFF
`define DIV_START_REM 33'h020000000
`define DIV_STEPS 5'h18

// calibration averaging and strobe timing
`define CAL_READINGS 5'h10
`define CAL_AVG_SHIFT 4
`define STROBE_HIGH_CYCLES 3'h4

`endif

/* File: verification/cal_engine_sva.sv */
// port checker for cal_engine, bound from the bench
// assumes one ref_clk domain and data periods longer than 26 clocks
`timescale 1ns/1ps
`default_nettype none
module cal_engine_sva (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // requests
    input wire logic filt_valid,
    input wire logic [31:0] filt_data,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic reg_rd,
    input wire logic [4:0] reg_addr,
    // answers
    input wire logic [7:0] reg_rdata,
    input wire logic result_valid,
    input wire logic [31:0] result_data,
    input wire logic cal_busy,
    input wire logic cont_read_on
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic ofs_kind;
    logic [4:0] n_meas;
    // kind of calibration armed, results measured while busy
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ofs_kind <= 1'b0;
            n_meas <= 5'h00;
        end else begin
            if (cmd_valid && !cal_busy && cmd_code[7:1] == 7'h30)
                ofs_kind <= !cmd_code[0];
            if (!cal_busy)
                n_meas <= 5'h00;
            else if (result_valid && cont_read_on)
                n_meas <= n_meas + 5'h01;
        end
    end
    // a calibration command the engine must accept
    sequence s_arm;
        cmd_valid && !cont_read_on && !cal_busy && cmd_code[7:1] == 7'h30;
    endsequence
    // a result taken into the calibration average
    sequence s_meas;
        cal_busy && cont_read_on && result_valid;
    endsequence
    res_latency_a: assert property (filt_valid |-> ##2 result_valid)
        else $error("no result two cycles after a sample");
    res_source_a: assert property (result_valid |-> $past(filt_valid, 2))
        else $error("result without a sample");
    unmapped_read_a: assert property (
        reg_rd && reg_addr > 5'h05 |=> reg_rdata == 8'h00)
        else $error("unmapped index read not zero");
    stop_read_a: assert property (
        cmd_valid && cmd_code == 8'h11 |-> ##2 !cont_read_on)
        else $error("stop command ignored");
    run_read_a: assert property (
        cmd_valid && cmd_code == 8'h10 |-> ##2 cont_read_on)
        else $error("continuous read command ignored");
    // status flags trail the internal state by one register stage
    cal_arm_a: assert property (s_arm |-> ##2 cal_busy)
        else $error("calibration command not taken");
    gain_bypass_a: assert property (
        s_meas and ofs_kind |-> result_data == $past(filt_data, 2))
        else $error("offset calibration result was corrected");
    cal_length_a: assert property (s_meas |-> n_meas < 5'h10)
        else $error("calibration took more than 16 results");
endmodule // cal_engine_sva
`default_nettype wire

/* File: verification/host_model.sv */
// host controller model: command bytes and register port
// assumes ref_clk from the bench; outputs change on falling edges
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // clock and register answer
    input wire logic ref_clk,
    input wire logic [7:0] reg_rdata,
    // requests
    output logic cmd_valid,
    output logic [7:0] cmd_code,
    output logic reg_wr,
    output logic reg_rd,
    output logic [4:0] reg_addr,
    output logic [7:0] reg_wdata
);
    // idle host
    initial begin
        cmd_valid = 1'b0;
        cmd_code = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 5'h00;
        reg_wdata = 8'h00;
    end
    // released lines show the inverse, never the stale value
    task send_cmd(input logic [7:0] code);
        @(negedge ref_clk);
        cmd_valid = 1'b1;
        cmd_code = code;
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        cmd_code = ~code;
        repeat (24) @(negedge ref_clk);
    endtask
    task write_reg(input logic [4:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge ref_clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    // read byte is valid one edge after the strobe
    task read_reg(input logic [4:0] a, output logic [7:0] d);
        @(negedge ref_clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge ref_clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask
endmodule // host_model
`default_nettype wire

/* File: verification/testbench.sv */
// bench for cal_engine: host model, filtered sample source, checks
// assumes host_model and cal_engine_sva are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic ref_clk, rst, filt_valid, data_read, sync_pin;
    logic cmd_valid, reg_wr, reg_rd;
    logic [7:0] cmd_code, reg_wdata, reg_rdata, b;
    logic [4:0] reg_addr;
    logic [31:0] filt_data, result_data, got;
    logic [23:0] word;
    logic result_valid, result_ready_strobe_n;
    logic cal_busy, cal_abort, cont_read_on;
    int n_fail, n_compared;

    cal_engine DUT (.ref_clk, .rst, .filt_valid, .filt_data, .cmd_valid,
        .cmd_code, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .data_read, .sync_pin, .result_valid, .result_data,
        .result_ready_strobe_n, .cal_busy, .cal_abort, .cont_read_on);
    host_model h (.ref_clk, .reg_rdata, .cmd_valid, .cmd_code, .reg_wr,
        .reg_rd, .reg_addr, .reg_wdata);

    // 20 MHz reference clock
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task give_verdict;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task check(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task time_out;
        n_fail++;
        $display("mismatch at %0t: wait ran out", $time);
        give_verdict;
    endtask

    // expected code: offset first, then gain, both steps saturating
    function automatic longint sat(input longint v);
        return v > 64'sh7FFFFFFF ? 64'sh7FFFFFFF :
            (v < -64'sh80000000 ? -64'sh80000000 : v);
    endfunction
    function automatic logic [31:0] model(input logic [31:0] d,
            input logic [23:0] o, input logic [23:0] g);
        longint t;
        t = sat(sat(longint'($signed(d)) - (longint'($signed(o)) <<< 8))
            * longint'(g) >>> 22);
        return t[31:0];
    endfunction

    // one sample, result caught, then the rest of a 39-clock period
    task sample(input logic [31:0] d);
        int k;
        @(negedge ref_clk);
        filt_valid = 1'b1;
        filt_data = d;
        @(negedge ref_clk);
        filt_valid = 1'b0;
        filt_data = ~d;
        for (k = 0; k < 4 && result_valid !== 1'b1; k++)
            @(negedge ref_clk);
        if (k == 4)
            time_out;
        got = result_data;
        repeat (36) @(negedge ref_clk);
    endtask
    // words go a byte at a time, low byte at the lowest index
    task set_words(input logic [23:0] o, input logic [23:0] g);
        for (int i = 0; i < 3; i++) begin
            h.write_reg(5'(i), o[8*i +: 8]);
            h.write_reg(5'(i + 3), g[8*i +: 8]);
        end
    endtask
    task get_word(input logic [4:0] base);
        for (int i = 0; i < 3; i++) begin
            h.read_reg(base + 5'(i), b);
            word[8*i +: 8] = b;
        end
    endtask
    task scale_case(input logic [31:0] d, input logic [23:0] o,
            input logic [23:0] g);
        set_words(o, g);
        sample(d);
        check(got, model(d, o, g));
    endtask
    // host calibration flow, sync kept high by the bench
    task cal_run(input logic [7:0] code, input logic [31:0] level);
        int k;
        h.send_cmd(8'h11);
        h.send_cmd(8'h04);
        h.send_cmd(8'h10);
        sample(level);
        check(result_ready_strobe_n, 1'b0);
        h.send_cmd(8'h11);
        h.send_cmd(code);
        check(cal_busy, 1'b1);
        h.send_cmd(8'h10);
        for (k = 0; k < 16; k++)
            sample(level + (k[0] ? 32'h40 : -32'h40));
        check(cal_busy, 1'b0);
    endtask

    task t_reset;
        get_word(5'h00);
        check(word, 24'h000000);
        get_word(5'h03);
        check(word, 24'h400000);
    endtask
    task t_regs;
        set_words(24'h332211, 24'h6655AA);
        get_word(5'h00);
        check(word, 24'h332211);
        get_word(5'h03);
        check(word, 24'h6655AA);
        h.write_reg(5'h06, 8'h5A);
        h.read_reg(5'h06, b);
        check(b, 8'h00);
    endtask
    task t_scale;
        scale_case(32'h00000000, 24'h332211, 24'h6655AA);
        scale_case(32'h00000000, 24'h000001, 24'h400000);
        scale_case(32'h00000000, 24'h7FFFFF, 24'h400000);
        scale_case(32'h00000000, 24'h800000, 24'h400000);
        scale_case(32'h10000000, 24'h000000, 24'h800000);
        scale_case(32'h10000000, 24'h000000, 24'h200000);
        scale_case(32'h10000000, 24'h000000, 24'h000000);
        scale_case(32'h10001000, 24'h000010, 24'h800000);
        scale_case(32'h60000000, 24'h000000, 24'h800000);
        scale_case(32'hA0000000, 24'h000000, 24'h800000);
    endtask
    task t_strobe;
        sample(32'h00000100);
        check(result_ready_strobe_n, 1'b0);
        @(negedge ref_clk);
        data_read = 1'b1;
        @(negedge ref_clk);
        data_read = 1'b0;
        check(result_ready_strobe_n, 1'b1);
        h.send_cmd(8'h11);
        sample(32'h00000100);
        check({cont_read_on, result_ready_strobe_n}, 2'b01);
    endtask
    task t_ofs_cal;
        set_words(24'h111111, 24'h200000);
        cal_run(8'h60, 32'h00012300);
        get_word(5'h00);
        check(word, 24'h000123);
        get_word(5'h03);
        check(word, 24'h200000);
        sample(32'h00012500);
        check(got, model(32'h00012500, 24'h000123, 24'h200000));
    endtask
    task t_gain_cal;
        longint gexp;
        gexp = (64'sh1 <<< 53) / 64'sh70000000;
        cal_run(8'h61, 32'h70012300);
        get_word(5'h03);
        check(word, gexp[23:0]);
        sample(32'h38012300);
        check(got, model(32'h38012300, 24'h000123, gexp[23:0]));
    endtask
    // sync lost while armed: abort flag up, offset word untouched
    task t_abort;
        h.send_cmd(8'h11);
        h.send_cmd(8'h60);
        check(cal_abort, 1'b0);
        sync_pin = 1'b0;
        repeat (4) @(negedge ref_clk);
        check(cal_abort, 1'b1);
        check(cal_busy, 1'b0);
        sync_pin = 1'b1;
        h.send_cmd(8'h10);
        get_word(5'h00);
        check(word, 24'h000123);
    endtask
    // host-side calibration by plain register writes
    task t_soft_cal;
        longint acc, gsw;
        acc = 0;
        set_words(24'h000000, 24'h400000);
        for (int k = 0; k < 4; k++) begin
            sample(32'h00004500 + (k[0] ? 32'h40 : -32'h40));
            acc += longint'(got);
        end
        set_words(24'(acc >>> 10), 24'h400000);
        get_word(5'h00);
        check(word, 24'h000045);
        sample(32'h30004500);
        check(got, 32'h30000000);
        gsw = 64'sh400000 * 64'sh20000000 / longint'(got);
        set_words(24'h000045, gsw[23:0]);
        sample(32'h30004500);
        check(got, model(32'h30004500, 24'h000045, gsw[23:0]));
    endtask

    // reset for 8 clocks, then the scenarios in order
    initial begin
        n_fail = 0;
        n_compared = 0;
        rst = 1'b1;
        filt_valid = 1'b0;
        filt_data = 32'h00000000;
        data_read = 1'b0;
        sync_pin = 1'b1;
        repeat (8) @(negedge ref_clk);
        rst = 1'b0;
        t_reset;
        t_regs;
        t_scale;
        t_strobe;
        t_ofs_cal;
        t_gain_cal;
        t_abort;
        t_soft_cal;
        give_verdict;
    end
endmodule // testbench

bind cal_engine cal_engine_sva chk (.ref_clk, .rst, .filt_valid, .filt_data,
    .cmd_valid, .cmd_code, .reg_rd, .reg_addr, .reg_rdata, .result_valid,
    .result_data, .cal_busy, .cont_read_on);
`default_nettype wire
